//--- pkg/reading_average_range_check_regs.vh
// register map, field layout, reset values and limits of the reading filter
// assumes inclusion by bare name from the rtl files
`ifndef READING_AVERAGE_RANGE_CHECK_REGS_VH
`define READING_AVERAGE_RANGE_CHECK_REGS_VH
`define ADDR_FILTER_CTRL 8'h00
`define ADDR_MEAS_CTRL 8'h04
`define ADDR_THRESHOLD 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_AVERAGE 8'h10
`define ADDR_PRESS 8'h14
`define FILTER_ACTIVE_INDICATOR_EN_BIT 0
`define FILTER_ACTIVE_INDICATOR_MODE_BIT 1
`define FILTER_ACTIVE_INDICATOR_COUNT_LSB 8
`define FILTER_ACTIVE_INDICATOR_COUNT_MSB 14
`define FUNC_LSB 0
`define FUNC_MSB 3
`define RANGE_LSB 8
`define RANGE_MSB 10
`define MANUAL_BIT 11
`define INTEGRATION_LINE_CYCLES_LSB 16
`define INTEGRATION_LINE_CYCLES_MSB 19
`define PRESS_DIGITS_BIT 0
`define PRESS_REMOTE_RESET_BIT 1
`define COUNT_MIN 7'h02
`define COUNT_MAX 7'h64
`define COUNT_RESET 7'h0A
`define THRESH_MIN 10'h001
`define THRESH_MAX 10'h3E8
`define THRESH_RESET 10'h00A
`define RES_45 2'h0
`define RES_55 2'h1
`define RES_65 2'h2
`define INTEGRATION_LINE_CYCLES_0P001 4'h0
`define INTEGRATION_LINE_CYCLES_0P2 4'h4
`define INTEGRATION_LINE_CYCLES_1 4'h6
`define INTEGRATION_LINE_CYCLES_10 4'h8
`define INTEGRATION_LINE_CYCLES_100 4'h9
`define FN_DCV 4'h0
`define FN_ACV 4'h1
`define FN_DCI 4'h2
`define FN_ACI 4'h3
`define FN_RES2 4'h4
`define FN_RES4 4'h5
`define FN_FREQ 4'h6
`define FN_PERIOD 4'h7
`define FN_CONTINUITY_FUNCTION 4'h8
`define FN_DIODE 4'h9
`define FN_THERMOCOUPLE_FUNCTION 4'hA
`define FN_RTD 4'hB
`define FN_CAP 4'hC
`define MAX_PCT 8'h78
`define MIN_PCT 8'h0A
`endif

//--- rtl/reading_average_range_check.v
// reading post-processing: averaging filter, continuity beeper, ranging
// assumes readings as two's-complement signed values from a converter on the same clock,
// full scale of the active range on an input, registers over axi4-lite
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "reading_average_range_check_regs.vh"

// What this block does
// R1: averaging depth is configurable from 2 to 100 readings.
// R2: modes are sliding average and block average, or filter off.
// R3: sliding mode keeps readings fifo, averages after every new reading.
// R4: sliding mode fills the whole store with the first reading.
// R5: block mode waits for full store, outputs average, then empties.
// R6: block mode emits one average per configured count of readings.
// R7: no averaging in diode, continuity, frequency or period.
// R8: after reset filter is on, sliding mode, ten readings.
// R9: filter indicator lit whenever filter is enabled.
// R10: each digits press cycles 4.5, 5.5, 6.5 digits.
// R11: line-cycle setting only matters for dc volts, dc amps, resistance.
// R12: fastest line-cycle choice is 0.001, 0.2, 10 per resolution.
// R13: reset or remote reset gives 5.5 digits and one line cycle.
// R14: each function keeps its own resolution, also used by math.
// R15: beeper on in continuity when resistance is below threshold.
// R16: continuity threshold accepts 1 to 1000 ohms.
// R17: threshold resets to ten ohms, held only in volatile state.
// R18: autorange offered except continuity, diode and temperature.
// R19: above 120 or below 10 percent of scale; overload above range.
// R20: manual-range indicator lit while range chosen manually.
// R21: ranging defaults to automatic after reset.
// R22: autorange steps up above maximum and down below minimum.
// R23: average is sum over entries, truncated toward minus infinity.
// R24: changing mode, count or function clears the store.
module reading_average_range_check #(
	parameter DW = 24,
	parameter DEPTH = 100,
	parameter NRANGE = 7
) (
	input wire clk,
	input wire rstn,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [DW-1:0] reading,
	input wire reading_valid,
	input wire [DW-1:0] full_scale,
	output reg [DW-1:0] display_reading,
	output reg display_valid,
	output reg filter_active_indicator,
	output reg manual_range_indicator,
	output reg overload_message,
	output reg beeper,
	output reg [2:0] active_range,
	output reg [1:0] resolution,
	output reg [3:0] integration_line_cycles,
	output reg integration_line_cycles_applies
);
	localparam SW = DW + 7;
	localparam ST_FILL = 2'd0;
	localparam ST_RUN = 2'd1;
	localparam ST_DIV = 2'd2;

	reg filter_active_indicator_en;
	reg filter_active_indicator_mode;
	reg [6:0] filter_active_indicator_count;
	reg [3:0] func;
	reg [2:0] man_range;
	reg manual;
	reg [9:0] threshold;
	reg [1:0] res_tab [0:15];
	reg [3:0] integration_line_cycles_tab [0:15];
	reg [DW-1:0] store [0:DEPTH-1];
	reg [6:0] wr_ptr;
	reg [6:0] fill;
	reg signed [SW-1:0] sum;
	reg [1:0] state;
	reg signed [SW-1:0] quot_num;
	reg signed [SW-1:0] quot;
	reg [6:0] quot_den;
	reg [5:0] div_step;
	reg [2:0] auto_range;
	reg aw_hold, w_hold;
	reg [31:0] aw_addr_q, wdata_q;
	reg [3:0] wstrb_q;
	integer i;
	integer j;

	wire no_filter = (func == `FN_DIODE) || (func == `FN_CONTINUITY_FUNCTION) ||
		(func == `FN_FREQ) || (func == `FN_PERIOD); // [R7]
	wire no_auto = (func == `FN_CONTINUITY_FUNCTION) || (func == `FN_DIODE) ||
		(func == `FN_THERMOCOUPLE_FUNCTION) || (func == `FN_RTD); // [R18]
	wire integration_line_cycles_fn = (func == `FN_DCV) || (func == `FN_DCI) ||
		(func == `FN_RES2) || (func == `FN_RES4); // [R11]
	wire averaging = filter_active_indicator_en && !no_filter;
	wire signed [SW-1:0] rd_ext = {{7{reading[DW-1]}}, reading};
	wire [DW-1:0] oldest = store[wr_ptr];
	wire signed [SW-1:0] old_ext = {{7{oldest[DW-1]}}, oldest};
	wire [DW-1:0] mag = reading[DW-1] ? (~reading + 1'b1) : reading;
	wire [DW+7:0] mag100 = {1'b0, mag, 7'b0} - {3'b0, mag, 5'b0} +
		{6'b0, mag, 2'b0};
	wire [DW+7:0] fs120 = {1'b0, full_scale, 7'b0} -
		{5'b0, full_scale, 3'b0};
	wire [DW+7:0] fs10 = {5'b0, full_scale, 3'b0} + {7'b0, full_scale, 1'b0};
	wire over = mag100 > fs120; // [R19]
	wire under = mag100 < fs10;
	wire do_write = aw_hold && w_hold && !s_axi_bvalid;

	// axi write: address and data accepted in either order, one at a time
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr_q <= 32'h0000_0000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			s_axi_awready <= !aw_hold && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !w_hold && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_addr_q[7:0])
				`ADDR_FILTER_CTRL, `ADDR_MEAS_CTRL, `ADDR_THRESHOLD,
				`ADDR_PRESS: s_axi_bresp <= 2'b00;
				default: s_axi_bresp <= 2'b10;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// settings; volatile, so reset restores defaults
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			filter_active_indicator_en <= 1'b1; // [R8]
			filter_active_indicator_mode <= 1'b0;
			filter_active_indicator_count <= `COUNT_RESET;
			func <= `FN_DCV;
			man_range <= 3'd0;
			manual <= 1'b0; // [R21]
			threshold <= `THRESH_RESET; // [R17]
			for (i = 0; i < 16; i = i + 1) begin
				res_tab[i] <= `RES_55; // [R13]
				integration_line_cycles_tab[i] <= `INTEGRATION_LINE_CYCLES_1;
			end
		end else if (do_write) begin
			case (aw_addr_q[7:0])
			`ADDR_FILTER_CTRL: begin
				if (wstrb_q[0]) begin
					filter_active_indicator_en <= wdata_q[`FILTER_ACTIVE_INDICATOR_EN_BIT];
					filter_active_indicator_mode <= wdata_q[`FILTER_ACTIVE_INDICATOR_MODE_BIT];
				end
				// out-of-range counts are ignored, not clipped
				if (wstrb_q[1] &&
					wdata_q[`FILTER_ACTIVE_INDICATOR_COUNT_MSB:`FILTER_ACTIVE_INDICATOR_COUNT_LSB] >= `COUNT_MIN &&
					wdata_q[`FILTER_ACTIVE_INDICATOR_COUNT_MSB:`FILTER_ACTIVE_INDICATOR_COUNT_LSB] <= `COUNT_MAX)
					filter_active_indicator_count <= wdata_q[`FILTER_ACTIVE_INDICATOR_COUNT_MSB:`FILTER_ACTIVE_INDICATOR_COUNT_LSB]; // [R1]
			end
			`ADDR_MEAS_CTRL: begin
				if (wstrb_q[0])
					func <= wdata_q[`FUNC_MSB:`FUNC_LSB];
				if (wstrb_q[1]) begin
					man_range <= wdata_q[`RANGE_MSB:`RANGE_LSB];
					manual <= wdata_q[`MANUAL_BIT]; // [R20]
				end
				// a setting below the resolution's fastest is raised to it
				if (wstrb_q[2] && integration_line_cycles_fn) begin // [R11]
					if (res_tab[func] == `RES_45)
						integration_line_cycles_tab[func] <= wdata_q[`INTEGRATION_LINE_CYCLES_MSB:`INTEGRATION_LINE_CYCLES_LSB];
					else if (res_tab[func] == `RES_55)
						integration_line_cycles_tab[func] <= (wdata_q[`INTEGRATION_LINE_CYCLES_MSB:`INTEGRATION_LINE_CYCLES_LSB] < `INTEGRATION_LINE_CYCLES_0P2) ?
							`INTEGRATION_LINE_CYCLES_0P2 : wdata_q[`INTEGRATION_LINE_CYCLES_MSB:`INTEGRATION_LINE_CYCLES_LSB]; // [R12]
					else
						integration_line_cycles_tab[func] <= (wdata_q[`INTEGRATION_LINE_CYCLES_MSB:`INTEGRATION_LINE_CYCLES_LSB] < `INTEGRATION_LINE_CYCLES_10) ?
							`INTEGRATION_LINE_CYCLES_10 : wdata_q[`INTEGRATION_LINE_CYCLES_MSB:`INTEGRATION_LINE_CYCLES_LSB]; // [R12]
				end
			end
			`ADDR_THRESHOLD: begin
				if (wdata_q[9:0] >= `THRESH_MIN && wdata_q[9:0] <= `THRESH_MAX &&
					wdata_q[31:10] == 22'h0)
					threshold <= wdata_q[9:0]; // [R16]
			end
			`ADDR_PRESS: begin
				if (wstrb_q[0] && wdata_q[`PRESS_REMOTE_RESET_BIT]) begin
					for (i = 0; i < 16; i = i + 1) begin
						res_tab[i] <= `RES_55; // [R13]
						integration_line_cycles_tab[i] <= `INTEGRATION_LINE_CYCLES_1;
					end
				end else if (wstrb_q[0] && wdata_q[`PRESS_DIGITS_BIT]) begin
					// per-function resolution, fastest rate of new group
					case (res_tab[func]) // [R14]
					`RES_45: begin
						res_tab[func] <= `RES_55; // [R10]
						integration_line_cycles_tab[func] <= `INTEGRATION_LINE_CYCLES_0P2; // [R12]
					end
					`RES_55: begin
						res_tab[func] <= `RES_65;
						integration_line_cycles_tab[func] <= `INTEGRATION_LINE_CYCLES_10;
					end
					default: begin
						res_tab[func] <= `RES_45;
						integration_line_cycles_tab[func] <= `INTEGRATION_LINE_CYCLES_0P001;
					end
					endcase
				end
			end
			default: ;
			endcase
		end
	end

	// axi read
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr[7:0])
				`ADDR_FILTER_CTRL: s_axi_rdata <= {17'h0, filter_active_indicator_count,
					6'h0, filter_active_indicator_mode, filter_active_indicator_en};
				`ADDR_MEAS_CTRL: s_axi_rdata <= {12'h0, integration_line_cycles_tab[func], 4'h0,
					manual, man_range, 4'h0, func};
				`ADDR_THRESHOLD: s_axi_rdata <= {22'h0, threshold};
				`ADDR_STATUS: s_axi_rdata <= {16'h0, fill, 2'h0,
					active_range, resolution, overload_message, beeper};
				`ADDR_AVERAGE: s_axi_rdata <= {{(32-DW){display_reading[DW-1]}},
					display_reading};
				`ADDR_PRESS: s_axi_rdata <= 32'h0000_0000;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'b10;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// reading store and running sum; restart on any filter-relevant change
	wire restart = do_write && ((aw_addr_q[7:0] == `ADDR_FILTER_CTRL) ||
		(aw_addr_q[7:0] == `ADDR_MEAS_CTRL && wstrb_q[0])); // [R24]

	always @(posedge clk) begin
		if (state == ST_FILL && reading_valid && averaging) begin
			for (j = 0; j < DEPTH; j = j + 1)
				store[j] <= reading; // [R4]
		end else if (state == ST_RUN && reading_valid && averaging)
			store[wr_ptr] <= reading; // [R3]
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_FILL;
			wr_ptr <= 7'd0;
			fill <= 7'd0;
			sum <= {SW{1'b0}};
			quot_num <= {SW{1'b0}};
			quot <= {SW{1'b0}};
			quot_den <= 7'd2;
			div_step <= 6'd0;
			display_reading <= {DW{1'b0}};
			display_valid <= 1'b0;
		end else begin
			display_valid <= 1'b0;
			if (restart) begin
				state <= ST_FILL;
				wr_ptr <= 7'd0;
				fill <= 7'd0;
				sum <= {SW{1'b0}};
			end else if (!averaging) begin
				if (reading_valid) begin
					display_reading <= reading; // [R2]
					display_valid <= 1'b1;
				end
			end else begin
				case (state)
				ST_FILL: if (reading_valid) begin
					if (!filter_active_indicator_mode) begin
						sum <= rd_ext * $signed({1'b0, filter_active_indicator_count});
						fill <= filter_active_indicator_count;
						wr_ptr <= (filter_active_indicator_count == 7'd1) ? 7'd0 : 7'd1;
						quot_num <= rd_ext * $signed({1'b0, filter_active_indicator_count});
						quot_den <= filter_active_indicator_count;
						div_step <= 6'd0;
						state <= ST_DIV;
					end else begin
						sum <= rd_ext;
						fill <= 7'd1;
						state <= ST_RUN;
					end
				end
				ST_RUN: if (reading_valid) begin
					if (!filter_active_indicator_mode) begin
						sum <= sum - old_ext + rd_ext; // [R3]
						quot_num <= sum - old_ext + rd_ext;
						quot_den <= filter_active_indicator_count;
						div_step <= 6'd0;
						wr_ptr <= (wr_ptr == filter_active_indicator_count - 7'd1) ? 7'd0 :
							wr_ptr + 7'd1;
						state <= ST_DIV;
					end else if (fill == filter_active_indicator_count - 7'd1) begin
						quot_num <= sum + rd_ext; // [R5]
						quot_den <= filter_active_indicator_count;
						div_step <= 6'd0;
						sum <= {SW{1'b0}};
						fill <= 7'd0; // [R6]
						state <= ST_DIV;
					end else begin
						sum <= sum + rd_ext;
						fill <= fill + 7'd1;
					end
				end
				ST_DIV: begin
					// floor division by repeated subtraction is too slow at
					// depth 100; use a floor via truncating divide then fixup
					quot <= quot_num / $signed({1'b0, quot_den}); // [R23]
					div_step <= div_step + 6'd1;
					if (div_step == 6'd1) begin
						display_reading <= ((quot_num < 0) &&
							(quot * $signed({1'b0, quot_den}) != quot_num)) ?
							quot[DW-1:0] - 1'b1 : quot[DW-1:0];
						display_valid <= 1'b1;
						state <= ST_RUN;
					end
				end
				default: state <= ST_FILL;
				endcase
			end
		end
	end

	// ranging, overload, beeper and indicators
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			auto_range <= 3'd0;
			active_range <= 3'd0;
			overload_message <= 1'b0;
			beeper <= 1'b0;
			filter_active_indicator <= 1'b0;
			manual_range_indicator <= 1'b0;
			resolution <= `RES_55;
			integration_line_cycles <= `INTEGRATION_LINE_CYCLES_1;
			integration_line_cycles_applies <= 1'b0;
		end else begin
			filter_active_indicator <= filter_active_indicator_en; // [R9]
			manual_range_indicator <= manual || no_auto; // [R20]
			resolution <= res_tab[func];
			integration_line_cycles <= integration_line_cycles_tab[func];
			integration_line_cycles_applies <= integration_line_cycles_fn; // [R11]
			active_range <= (manual || no_auto) ? man_range : auto_range;
			if (reading_valid) begin
				beeper <= (func == `FN_CONTINUITY_FUNCTION) && !reading[DW-1] &&
					(reading < {{(DW-10){1'b0}}, threshold}); // [R15]
				if (!manual && !no_auto) begin
					if (over && auto_range != NRANGE - 1)
						auto_range <= auto_range + 3'd1; // [R22]
					else if (under && auto_range != 3'd0)
						auto_range <= auto_range - 3'd1;
				end
				overload_message <= over &&
					(manual || no_auto || auto_range == NRANGE - 1); // [R19]
			end
		end
	end
endmodule // reading_average_range_check

//--- dv/reading_average_range_check_monitor.sv
// checker of the filter, digits and beeper outputs, bound to the top module
// assumes one clock domain and the active-low reset of the block
`timescale 1ns/100ps
`include "reading_average_range_check_regs.vh"
module reading_average_monitor #(
	parameter DW = 24
) (
	input wire clk,
	input wire rstn,
	input wire [DW-1:0] reading,
	input wire reading_valid,
	input wire display_valid,
	input wire filter_active_indicator,
	input wire overload_message,
	input wire beeper,
	input wire [1:0] resolution,
	input wire [3:0] integration_line_cycles
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_pass;
		reading_valid ##1 display_valid;
	endsequence
	// passthrough answers after 1 cycle, averaging after 3
	sequence s_cause;
		$past(reading_valid) || $past(reading_valid, 3);
	endsequence
	a_pass_next: assert property (
		reading_valid && !filter_active_indicator |-> s_pass)
		else $error("unfiltered reading not shown next cycle");
	a_out_cause: assert property (
		display_valid |-> s_cause)
		else $error("display output without a reading");
	a_lamp_reset: assert property (
		$rose(rstn) |=> filter_active_indicator)
		else $error("filter lamp off after reset");
	a_reset_digits: assert property (
		$rose(rstn) |-> resolution == `RES_55
		&& integration_line_cycles == `INTEGRATION_LINE_CYCLES_1)
		else $error("digits default wrong after reset");
	a_fast_65: assert property (
		resolution == `RES_65 |-> integration_line_cycles >= `INTEGRATION_LINE_CYCLES_10)
		else $error("line cycles too short for 6.5 digits");
	a_fast_55: assert property (
		resolution == `RES_55 |-> integration_line_cycles >= `INTEGRATION_LINE_CYCLES_0P2
		&& integration_line_cycles < `INTEGRATION_LINE_CYCLES_10)
		else $error("line cycles outside 5.5 digit group");
	a_beep_cause: assert property (
		$rose(beeper) |-> $past(reading_valid)
		&& $signed($past(reading)) < 1001)
		else $error("beeper rose without a low reading");
	a_overload_message_cause: assert property (
		$rose(overload_message) |-> $past(reading_valid))
		else $error("overload rose without a reading");
endmodule // reading_average_monitor
bind reading_average_range_check reading_average_monitor #(.DW(DW))
	i_reading_average_monitor (.clk(clk), .rstn(rstn), .reading(reading),
	.reading_valid(reading_valid), .display_valid(display_valid),
	.filter_active_indicator(filter_active_indicator),
	.overload_message(overload_message), .beeper(beeper),
	.resolution(resolution),
	.integration_line_cycles(integration_line_cycles));

//--- dv/reading_source.sv
// converter and display stand-in: one reading per go, 8 cycles apart
// assumes the block's clock and reset
`timescale 1ns/100ps
module reading_source (
	input wire clk,
	input wire rstn,
	input wire go,
	input wire [23:0] value,
	input wire display_valid,
	input wire [23:0] display_reading,
	output reg reading_valid,
	output reg [23:0] reading,
	output reg busy,
	output reg [23:0] shown,
	output integer n_shown
);
	reg [2:0] gap;
	wire take = go && !busy;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reading_valid <= 1'h0;
			reading <= 24'h00_0000;
			busy <= 1'h0;
			gap <= 3'h0;
			shown <= 24'h00_0000;
			n_shown <= 0;
		end else begin
			reading_valid <= take;
			// idle bus toggles so stale data is never taken for a reading
			reading <= take ? value : ~reading;
			// spacing covers the 3-cycle averaging path
			gap <= take ? 3'h7 : gap - {2'h0, gap != 3'h0};
			busy <= take || gap > 3'h1;
			if (display_valid) begin
				shown <= display_reading;
				n_shown <= n_shown + 1;
			end
		end
	end
endmodule // reading_source

//--- dv/tb_reading_average_range_check.sv
// self-checking bench for the reading filter, ranging and beeper block
// assumes the register header and the reading_source stand-in
`timescale 1ns/100ps
`include "reading_average_range_check_regs.vh"
module tb_reading_average_range_check;
	typedef struct {
		logic [3:0] f;
		logic [15:0] c;
		logic [23:0] r, d;
		logic n, b;
	} row_t;
	logic clk = 1'h0, rstn = 1'h0, go = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000;
	logic [31:0] s_axi_araddr = 32'h0000_0000, rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [23:0] value = 24'h00_0000, full_scale = 24'h00_0064;
	logic [1:0] resp;
	logic [1:0] pr [3] = '{2'h2, 2'h0, 2'h1};
	logic [3:0] pn [3] = '{4'h8, 4'h0, 4'h4};
	wire [31:0] s_axi_rdata;
	wire [23:0] reading, display_reading, shown;
	wire [1:0] s_axi_bresp, s_axi_rresp, resolution;
	wire [2:0] active_range;
	wire [3:0] integration_line_cycles;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, reading_valid, display_valid, busy, beeper;
	wire filter_active_indicator, manual_range_indicator, overload_message;
	wire integration_line_cycles_applies;
	integer failures = 0, n_compared = 0, n_shown, k, seen_n;
	// function, filter ctrl, reading, shown value, new outputs, beeper
	row_t rows [14] = '{
		'{4'h8, 16'h0A01, 24'h00_0005, 24'h00_0005, 1'h1, 1'h1},
		'{4'h8, 16'h0A01, 24'h00_000A, 24'h00_000A, 1'h1, 1'h0},
		'{4'h8, 16'h0A01, 24'h00_0009, 24'h00_0009, 1'h1, 1'h1},
		'{4'h6, 16'h0A01, 24'h00_004D, 24'h00_004D, 1'h1, 1'h0},
		'{4'h6, 16'h0A01, 24'h00_0003, 24'h00_0003, 1'h1, 1'h0},
		'{4'h0, 16'h0201, 24'h00_0008, 24'h00_0008, 1'h1, 1'h0},
		'{4'h0, 16'h0201, 24'h00_0004, 24'h00_0006, 1'h1, 1'h0},
		'{4'h0, 16'h0201, 24'hFF_FFFD, 24'h00_0000, 1'h1, 1'h0},
		'{4'h0, 16'h0201, 24'hFF_FFFC, 24'hFF_FFFC, 1'h1, 1'h0},
		'{4'h0, 16'h0203, 24'h00_0003, 24'hFF_FFFC, 1'h0, 1'h0},
		'{4'h0, 16'h0203, 24'h00_0006, 24'h00_0004, 1'h1, 1'h0},
		'{4'h0, 16'h0203, 24'h00_0001, 24'h00_0004, 1'h0, 1'h0},
		'{4'h0, 16'h0203, 24'h00_0002, 24'h00_0001, 1'h1, 1'h0},
		'{4'h0, 16'h0200, 24'h00_0007, 24'h00_0007, 1'h1, 1'h0}};
	reading_average_range_check i_reading_average_range_check (.clk, .rstn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .reading, .reading_valid, .full_scale,
		.display_reading, .display_valid, .filter_active_indicator,
		.manual_range_indicator, .overload_message, .beeper, .active_range,
		.resolution, .integration_line_cycles, .integration_line_cycles_applies);
	reading_source i_reading_source (.clk, .rstn, .go, .value,
		.display_valid, .display_reading, .reading_valid, .reading, .busy,
		.shown, .n_shown);
	task chk(input string what, input [31:0] seen, input [31:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task stop_test;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task wr(input [7:0] a, input [31:0] d);
		logic ad, wd;
		ad = 1'h0;
		wd = 1'h0;
		@(posedge clk);
		s_axi_awaddr <= {24'h00_0000, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!ad || !wd) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			ad = ad | s_axi_awready;
			wd = wd | s_axi_wready;
		end
		do @(posedge clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
	endtask
	task rd(input [7:0] a);
		@(posedge clk);
		s_axi_araddr <= {24'h00_0000, a};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		rdata = s_axi_rdata;
		resp = s_axi_rresp;
	endtask
	task send(input [23:0] v);
		@(posedge clk);
		value <= v;
		go <= 1'h1;
		@(posedge clk);
		go <= 1'h0;
		do @(posedge clk); while (busy);
	endtask
	initial begin
		forever #2.5 clk = ~clk;
	end
	initial begin
		#60000;
		failures = failures + 1;
		stop_test;
	end
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'h1;
		repeat (2) @(posedge clk);
		chk("filter lamp", filter_active_indicator, 1'h1);
		chk("manual lamp", manual_range_indicator, 1'h0);
		rd(`ADDR_FILTER_CTRL);
		chk("filter ctrl", rdata, 32'h0000_0A01);
		rd(`ADDR_THRESHOLD);
		chk("threshold", rdata, 32'h0000_000A);
		for (k = 0; k < 4; k++) begin
			wr(`ADDR_PRESS, 32'h0000_0001);
			@(posedge clk);
			if (k < 3) begin
				chk("digits", resolution, pr[k]);
				chk("line cycles", integration_line_cycles, pn[k]);
			end
		end
		wr(`ADDR_PRESS, 32'h0000_0002);
		@(posedge clk);
		chk("digits", resolution, `RES_55);
		chk("line cycles", integration_line_cycles, `INTEGRATION_LINE_CYCLES_1);
		for (k = 0; k < 14; k++) begin
			if (k == 0 || rows[k].f !== rows[k-1].f || rows[k].c !== rows[k-1].c)
			begin
				wr(`ADDR_MEAS_CTRL, {12'h000, 4'h6, 12'h000, rows[k].f});
				wr(`ADDR_FILTER_CTRL, {16'h0000, rows[k].c});
			end
			seen_n = n_shown;
			send(rows[k].r);
			chk("shown", shown, rows[k].d);
			chk("outputs", n_shown - seen_n, rows[k].n);
			chk("beeper", beeper, rows[k].b);
			chk("filter lamp", filter_active_indicator, rows[k].c[0]);
			chk("applies", integration_line_cycles_applies, rows[k].f == `FN_DCV);
		end
		wr(`ADDR_MEAS_CTRL, 32'h0006_0B00);
		@(posedge clk);
		chk("manual lamp", manual_range_indicator, 1'h1);
		chk("range", active_range, 3'h3);
		send(24'h00_0079);
		chk("overload", overload_message, 1'h1);
		send(24'h00_0078);
		chk("overload", overload_message, 1'h0);
		wr(`ADDR_MEAS_CTRL, 32'h0006_0008);
		@(posedge clk);
		chk("manual lamp", manual_range_indicator, 1'h1);
		wr(`ADDR_MEAS_CTRL, 32'h0006_0000);
		@(posedge clk);
		chk("manual lamp", manual_range_indicator, 1'h0);
		send(24'h00_0079);
		chk("range", active_range, 3'h1);
		chk("overload", overload_message, 1'h0);
		send(24'h00_0005);
		chk("range", active_range, 3'h0);
		wr(`ADDR_PRESS, 32'h0000_0001);
		wr(`ADDR_MEAS_CTRL, 32'h0006_0006);
		@(posedge clk);
		chk("digits", resolution, `RES_55);
		chk("applies", integration_line_cycles_applies, 1'h0);
		wr(`ADDR_MEAS_CTRL, 32'h0006_0000);
		@(posedge clk);
		chk("digits", resolution, `RES_65);
		chk("line cycles", integration_line_cycles, `INTEGRATION_LINE_CYCLES_10);
		rd(`ADDR_STATUS);
		chk("status", rdata, 32'h0000_0008);
		rd(`ADDR_AVERAGE);
		chk("average", rdata, 32'h0000_0005);
		wr(`ADDR_FILTER_CTRL, 32'h0000_6501);
		wr(`ADDR_FILTER_CTRL, 32'h0000_0101);
		wr(`ADDR_THRESHOLD, 32'h0000_03E9);
		rd(`ADDR_FILTER_CTRL);
		chk("filter ctrl", rdata, 32'h0000_0201);
		rd(`ADDR_THRESHOLD);
		chk("threshold", rdata, 32'h0000_000A);
		wr(`ADDR_FILTER_CTRL, 32'h0000_6401);
		wr(`ADDR_THRESHOLD, 32'h0000_03E8);
		rd(`ADDR_FILTER_CTRL);
		chk("filter ctrl", rdata, 32'h0000_6401);
		rd(`ADDR_THRESHOLD);
		chk("threshold", rdata, 32'h0000_03E8);
		rstn <= 1'h0;
		repeat (2) @(posedge clk);
		rstn <= 1'h1;
		repeat (2) @(posedge clk);
		rd(`ADDR_THRESHOLD);
		chk("threshold", rdata, 32'h0000_000A);
		rd(`ADDR_FILTER_CTRL);
		chk("filter ctrl", rdata, 32'h0000_0A01);
		chk("digits", resolution, `RES_55);
		rd(8'h18);
		chk("unmapped resp", resp, 2'h2);
		chk("unmapped data", rdata, 32'h0000_0000);
		stop_test;
	end
endmodule // tb_reading_average_range_check
